// ===== bench/breaker_model.sv
`timescale 1ns/1ps
// ------------------------------
// Breaker behind the trip coil
// ------------------------------
module breaker_model (
  input  wire logic i_clk,
  input  wire logic i_coil,
  input  wire logic i_slow,
  output logic      o_open
);
  int cnt_r = 0;

  // Contacts part after travel; slow mode stands for a stuck mechanism
  always_ff @(posedge i_clk) begin
    cnt_r  <= i_coil ? cnt_r + 1 : 0;
    o_open <= i_coil && (cnt_r >= (i_slow ? 150 : 10));
  end
endmodule // breaker_model

// ===== bench/freq_relay_chk.sv
`timescale 1ns/1ps
// ------------------------------
// Port checks of the relay
// ------------------------------
module freq_relay_chk
  import relay_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  input wire logic        o_primary_trip_out,
  input wire logic        o_backup_trip_out,
  input wire logic [2:0]  o_alarm_outs,
  input wire logic        o_alarm_indicator,
  input wire logic        o_trip_indicator
);
  logic       force_r;
  logic [7:0] bfc_r;
  int         prim_cnt;
  wire        wr_done = i_write && !o_waitrequest;
  wire        rd_done = i_read && !o_waitrequest;
  wire        plain = !force_r && bfc_r == BFC_RST;
  wire  [6:0] outs = {o_trip_indicator, o_alarm_indicator, o_alarm_outs,
                      o_backup_trip_out, o_primary_trip_out};

  // Shadow writes that reroute or override supervision
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      force_r <= 1'b0;
      bfc_r   <= BFC_RST;
    end else if (wr_done && i_address == A_CTRL) begin
      force_r <= i_writedata[CTRL_FORCE];
    end else if (wr_done && i_address == A_BF_CFG) begin
      bfc_r <= i_writedata[7:0];
    end
  end

  // Cycles the primary trip stood high; delay register kept at reset value
  always_ff @(posedge i_clk) begin
    prim_cnt <= (i_nrst && o_primary_trip_out) ? prim_cnt + 1 : 0;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_wait_once: assert property ($fell(o_waitrequest) |=> o_waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer: assert property (o_waitrequest && (i_read || i_write) |=> !o_waitrequest)
    else $error("request not answered in one cycle");
  a_rdata_hold: assert property (!(i_read && o_waitrequest) |=> $stable(o_readdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (rd_done && i_address == 8'hFC |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_clear_reads0: assert property (rd_done && i_address == A_CTRL |-> !o_readdata[CTRL_CLR])
    else $error("latch clear strobe reads back set");
  a_outs_readback: assert property (rd_done && i_address == A_OUTS |-> o_readdata[6:0] == $past(outs))
    else $error("output readback differs from pins");
  a_backup_late: assert property (plain && $rose(o_backup_trip_out) |-> prim_cnt >= int'(BFD_RST) * TICK_CYCLES)
    else $error("backup trip too early");
  a_backup_release: assert property (plain && $fell(o_primary_trip_out) |-> ##[0:3] !o_backup_trip_out)
    else $error("backup trip held after release");
endmodule // freq_relay_chk

bind freq_relay_top freq_relay_chk #(.TICK_CYCLES(TICK_CYCLES)) freq_relay_chk_i (.*);

// ===== bench/freq_relay_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
  end
module freq_relay_top_tb
  import relay_pkg::*;
();
  localparam int TCK = 4;
  localparam int D0 = int'(DLY0_RST);
  localparam logic [7:0] RA [10] = '{A_CTRL, A_LVB, A_BF_CFG, A_BF_DLY, A_IRQ_EN,
                                     8'h40, 8'h44, 8'h60, 8'h68, 8'hFC};
  localparam logic [31:0] RV [10] = '{32'h0, 32'(LVB_RST), 32'(BFC_RST), 32'(BFD_RST),
    32'h0, 32'(THR0_RST), 32'(DLY0_RST), 32'(THR1_RST), 32'(CFG_RST), 32'h0};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        dig = 1'b0;
  logic        kp = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  volt = 8'h64;
  logic [15:0] freq = 16'h1388;
  logic [31:0] wdata = 32'h0;
  logic [31:0] q;
  wire  [31:0] rdo;
  wire  [6:0]  outs;
  wire         wt;
  wire         irq;
  wire         brk_open;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc;

  freq_relay_top #(.TICK_CYCLES(TCK)) freq_relay_top_i (
    .i_clk(clk), .i_nrst(nrst), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .o_readdata(rdo), .o_waitrequest(wt), .i_freq(freq),
    .i_volt_pct(volt), .i_first_digital_input(dig), .i_keypad_reset(kp),
    .o_primary_trip_out(outs[0]), .o_backup_trip_out(outs[1]), .o_alarm_outs(outs[4:2]),
    .o_alarm_indicator(outs[5]), .o_trip_indicator(outs[6]), .o_irq(irq));
  breaker_model breaker_model_i (.i_clk(clk), .i_coil(outs[0]), .i_slow(slow),
                                 .o_open(brk_open));

  // Clock and watchdog
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #1_000_000;
    error_cnt++;
    give_verdict();
  end

  // ------------------------------
  // Bus and wait tasks
  // ------------------------------
  // One transfer; request held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wt !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    q = rdo;
    if (n == 20) error_cnt++;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // Edges until an output reaches a level; limit counts as a fault
  task automatic wait_out(input int b, input logic v, input int lim);
    cyc = 0;
    while (outs[b] !== v && cyc < lim) begin
      cyc++;
      @(posedge clk);
    end
    if (cyc == lim) error_cnt++;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------
  // Test sequence
  // ------------------------------
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    foreach (RA[i]) rchk(RA[i], RV[i]);
    $display("test reset_values done");
    xfer(1'b1, A_ROUTE, 32'h0020_2084);
    xfer(1'b1, A_LATCH, 32'h0000_2000);
    xfer(1'b1, A_IRQ_EN, 32'h0000_0001);
    // Short start first: a dropout must restart the delay from zero
    freq <= 16'h13ED;
    repeat (40) @(posedge clk);
    `CHK(outs[2:0], 3'b100)
    `CHK(irq, 1'b1)
    freq <= 16'h1388;
    repeat (3) @(posedge clk);
    freq <= 16'h13ED;
    wait_out(0, 1'b1, 200);
    `CHK(cyc >= (D0 - 1) * TCK && cyc <= (D0 + 1) * TCK + 4, 1'b1)
    xfer(1'b0, 8'h50, 32'h0);
    `CHK(q[15:0], {PCT_FULL, 8'h03})
    rchk(8'h4C, 32'h0001_0002);
    rchk(A_OUTS, 32'h0000_0045);
    xfer(1'b1, A_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wait (brk_open === 1'b1);
    freq <= 16'h1388;
    repeat (6) @(posedge clk);
    `CHK(outs, 7'h40)
    kp <= 1'b1;
    repeat (6) @(posedge clk);
    kp <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(outs[6], 1'b0)
    $display("test over_stage done");
    // Under stage with a stuck breaker brings in the backup trip
    slow <= 1'b1;
    xfer(1'b1, 8'h68, 32'h0000_00F0);
    wait_out(0, 1'b1, 100);
    `CHK(outs[0], 1'b1)
    wait_out(1, 1'b1, 150);
    `CHK(outs[1], 1'b1)
    xfer(1'b0, A_BF_TIME, 32'h0);
    `CHK(q > 32'd20, 1'b1)
    wait (brk_open === 1'b1);
    volt <= 8'h27;
    repeat (8) @(posedge clk);
    `CHK(outs[1:0], 2'b00)
    xfer(1'b0, A_IRQ_STAT, 32'h0);
    `CHK({q[8], q[4], irq}, 3'b110)
    xfer(1'b1, 8'h68, 32'h0000_00F1);
    volt <= 8'h64;
    $display("test breaker_failure done");
    // First input blocks stage 0 before it can start
    xfer(1'b1, A_BLOCK, 32'h0000_0001);
    dig <= 1'b1;
    repeat (4) @(posedge clk);
    freq <= 16'h13ED;
    repeat (20) @(posedge clk);
    `CHK(outs[2], 1'b0)
    dig <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(outs[2], 1'b1)
    freq <= 16'h1388;
    $display("test blocking done");
    give_verdict();
  end
endmodule // freq_relay_top_tb

// ===== rtl/breaker_failure_supervisor.sv
`timescale 1ns/1ps
module breaker_failure_supervisor (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_tick,
  input  wire logic        i_sup,
  input  wire logic        i_inhibit,
  input  wire logic [15:0] i_dly,
  output logic             o_backup,
  output logic [15:0]      o_time
);
  // Time since supervised output rose; saturates
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !i_sup) begin
      o_time <= 16'h0000; // [RULE_07]
    end else if (i_tick && o_time != 16'hFFFF) begin
      o_time <= o_time + 16'h0001; // [RULE_07]
    end
  end

  // Backup holds until the supervised output drops or forced test control inhibits it
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !i_sup || i_inhibit) begin
      o_backup <= 1'b0; // [RULE_10]
    end else if (o_time > i_dly) begin
      o_backup <= 1'b1; // [RULE_08]
    end
  end
endmodule // breaker_failure_supervisor

// ===== rtl/freq_relay_top.sv
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Two stages, own threshold and delay.
// RULE_02: Under mode starts when frequency below threshold.
// RULE_03: Trip only after uninterrupted full delay.
// RULE_04: Elapsed percent; 100 coincides with trip.
// RULE_05: Start counter counts start rising edges.
// RULE_06: Trip counter counts trip rising edges.
// RULE_07: Time supervised output from rise to fall.
// RULE_08: Overlong supervised output asserts held backup trip.
// RULE_09: Supervised and backup outputs are selectable.
// RULE_10: Supervision inhibited during forced test control.
// RULE_11: Any stage signal routes to any output.
// RULE_12: Each route is follower or latching.
// RULE_13: Latch reset clears all latches together; code keeps a latch set while its routed source is high in that cycle.
// RULE_14: Reset from keypad, bus, or configured input.
// RULE_15: Blocked stage never starts; running delay freezes.
// RULE_16: Input or stage signals block stages per bit.
// RULE_17: Over mode starts above threshold, trips after delay.
// RULE_18: Low voltage below limit holds stages inactive.
// RULE_19: Four event enables per stage, default on.
module freq_relay_top
  import relay_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  input  wire logic [15:0] i_freq,
  input  wire logic [7:0]  i_volt_pct,
  input  wire logic        i_first_digital_input,
  input  wire logic        i_keypad_reset,
  output logic             o_primary_trip_out,
  output logic             o_backup_trip_out,
  output logic [2:0]       o_alarm_outs,
  output logic             o_alarm_indicator,
  output logic             o_trip_indicator,
  output logic             o_irq
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  bus_state_t         bus_r;
  logic               we;
  logic               cmd_clr_r;
  logic               di_rst_r;
  logic               force_r;
  logic [7:0]         lvb_r;
  logic [7:0]         bfc_r;
  logic [15:0]        bfd_r;
  logic [27:0]        route_r;
  logic [27:0]        latch_mode_r;
  logic [9:0]         block_r;
  logic [6:0]         force_val_r;
  logic [N_EV-1:0]    irq_stat_r;
  logic [N_EV-1:0]    irq_en_r;
  logic [N_EV-1:0]    ev;
  logic [15:0]        thr_r   [N_STG];
  logic [15:0]        dly_r   [N_STG];
  logic [7:0]         cfg_r   [N_STG];
  logic               st_start[N_STG];
  logic               st_trip [N_STG];
  logic               prv_start_r[N_STG];
  logic               prv_trip_r [N_STG];
  logic [7:0]         st_pct  [N_STG];
  logic [15:0]        st_scnt [N_STG];
  logic [15:0]        st_tcnt [N_STG];
  logic [N_SRC-1:0]   src;
  logic [N_BLK-1:0]   blk_src;
  logic [27:0]        lat_r;
  logic [N_DST-1:0]   mat_out;
  logic [N_DST-1:0]   outs_r;
  logic [N_DST-1:0]   outs_nxt;
  logic               din_s1_r;
  logic               din_s2_r;
  logic               key_s1_r;
  logic               key_s2_r;
  logic               latch_clr;
  logic               lv_block;
  logic               sup;
  logic               backup;
  logic               prv_backup_r;
  logic [15:0]        bf_time;
  logic [31:0]        tick_cnt_r;
  logic               tick_r;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Stage register hit: returns stage index+1, zero when none
  function automatic logic [1:0] stage_hit(input logic [7:0] a, input logic [7:0] off);
    logic [1:0] r;
    r = 2'd0;
    for (int k = 0; k < N_STG; k++) begin
      if (a == 8'(A_STG_BASE + 8'(k) * A_STG_STEP + off)) r = 2'(k + 1);
    end
    return r;
  endfunction

  // Pick one of the seven outputs
  function automatic logic pick(input logic [N_DST-1:0] v, input logic [2:0] sel);
    return (sel < 3'(N_DST)) ? v[sel] : 1'b0;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Pins are asynchronous to the tick logic
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
      key_s1_r <= 1'b0;
      key_s2_r <= 1'b0;
    end else begin
      din_s1_r <= i_first_digital_input;
      din_s2_r <= din_s1_r;
      key_s1_r <= i_keypad_reset;
      key_s2_r <= key_s1_r;
    end
  end

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // One pulse per delay unit; all delays count these
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // One wait state per access keeps read data registered
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      bus_r         <= BUS_IDLE;
      o_waitrequest <= 1'b1;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (i_read || i_write) begin
            bus_r         <= BUS_ACK;
            o_waitrequest <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_r         <= BUS_IDLE;
          o_waitrequest <= 1'b1;
        end
        default: begin
          bus_r         <= BUS_IDLE;
          o_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  assign we = i_write && (bus_r == BUS_ACK);

  // Read mux; unmapped offsets read zero
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && bus_r == BUS_IDLE) begin
      o_readdata <= 32'h0000_0000;
      case (i_address)
        A_CTRL:     o_readdata <= {29'h0, force_r, di_rst_r, 1'b0};
        A_LVB:      o_readdata <= {24'h0, lvb_r};
        A_BF_CFG:   o_readdata <= {24'h0, bfc_r};
        A_BF_DLY:   o_readdata <= {16'h0, bfd_r};
        A_ROUTE:    o_readdata <= {4'h0, route_r};
        A_LATCH:    o_readdata <= {4'h0, latch_mode_r};
        A_BLOCK:    o_readdata <= {22'h0, block_r};
        A_FORCE:    o_readdata <= {25'h0, force_val_r};
        A_IRQ_STAT: o_readdata <= {23'h0, irq_stat_r};
        A_IRQ_EN:   o_readdata <= {23'h0, irq_en_r};
        A_OUTS:     o_readdata <= {25'h0, outs_r};
        A_BF_TIME:  o_readdata <= {16'h0, bf_time}; // [RULE_07]
        default: begin
          for (int k = 0; k < N_STG; k++) begin
            if (stage_hit(i_address, S_THR) == 2'(k + 1))
              o_readdata <= {16'h0, thr_r[k]};
            if (stage_hit(i_address, S_DLY) == 2'(k + 1))
              o_readdata <= {16'h0, dly_r[k]};
            if (stage_hit(i_address, S_CFG) == 2'(k + 1))
              o_readdata <= {24'h0, cfg_r[k]};
            if (stage_hit(i_address, S_CNT) == 2'(k + 1))
              o_readdata <= {st_tcnt[k], st_scnt[k]}; // [RULE_05] [RULE_06]
            if (stage_hit(i_address, S_STAT) == 2'(k + 1))
              o_readdata <= {16'h0, st_pct[k], 6'h0, st_trip[k], st_start[k]}; // [RULE_04]
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Global configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cmd_clr_r    <= 1'b0;
      di_rst_r     <= 1'b0;
      force_r      <= 1'b0;
      lvb_r        <= LVB_RST;
      bfc_r        <= BFC_RST;
      bfd_r        <= BFD_RST;
      route_r      <= 28'h000_0000;
      latch_mode_r <= 28'h000_0000;
      block_r      <= 10'h000;
      force_val_r  <= 7'h00;
    end else begin
      // Clear command is a one-cycle strobe
      cmd_clr_r <= we && i_address == A_CTRL && i_writedata[CTRL_CLR];
      if (we && i_address == A_CTRL) begin
        di_rst_r <= i_writedata[CTRL_DIRST];
        force_r  <= i_writedata[CTRL_FORCE];
      end
      if (we && i_address == A_LVB)    lvb_r        <= i_writedata[7:0];
      if (we && i_address == A_BF_CFG) bfc_r        <= i_writedata[7:0]; // [RULE_09]
      if (we && i_address == A_BF_DLY) bfd_r        <= i_writedata[15:0];
      if (we && i_address == A_ROUTE)  route_r      <= i_writedata[27:0]; // [RULE_11]
      if (we && i_address == A_LATCH)  latch_mode_r <= i_writedata[27:0]; // [RULE_12]
      if (we && i_address == A_BLOCK)  block_r      <= i_writedata[9:0]; // [RULE_16]
      if (we && i_address == A_FORCE)  force_val_r  <= i_writedata[6:0];
    end
  end

  // ----------------------------------------
  // Frequency stages
  // ----------------------------------------
  assign lv_block = i_volt_pct < lvb_r; // [RULE_18]
  assign blk_src  = {src, din_s2_r};

  for (genvar k = 0; k < N_STG; k++) begin : g_stg
    // Per-stage settings
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        thr_r[k] <= (k == 0) ? THR0_RST : THR1_RST;
        dly_r[k] <= (k == 0) ? DLY0_RST : DLY1_RST;
        cfg_r[k] <= CFG_RST; // [RULE_19]
      end else begin
        if (we && stage_hit(i_address, S_THR) == 2'(k + 1)) thr_r[k] <= i_writedata[15:0];
        if (we && stage_hit(i_address, S_DLY) == 2'(k + 1)) dly_r[k] <= i_writedata[15:0];
        if (we && stage_hit(i_address, S_CFG) == 2'(k + 1)) cfg_r[k] <= i_writedata[7:0];
      end
    end

    freq_stage u_stage (
      .i_clk         (i_clk),
      .i_nrst        (i_nrst),
      .i_tick        (tick_r),
      .i_freq        (i_freq),
      .i_thr         (thr_r[k]),
      .i_dly         (dly_r[k]),
      .i_over        (cfg_r[k][CFG_OVER]),
      .i_block       (|(blk_src & block_r[k*N_BLK +: N_BLK])), // [RULE_16] [RULE_15]
      .i_lv_block    (lv_block),
      .o_start       (st_start[k]),
      .o_trip        (st_trip[k]),
      .o_pct         (st_pct[k]),
      .o_start_count (st_scnt[k]),
      .o_trip_count  (st_tcnt[k])
    ); // [RULE_01]

    assign src[2*k]   = st_start[k];
    assign src[2*k+1] = st_trip[k];

    // Event edges: start on, start off, trip on, trip off
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        prv_start_r[k] <= 1'b0;
        prv_trip_r[k]  <= 1'b0;
      end else begin
        prv_start_r[k] <= st_start[k];
        prv_trip_r[k]  <= st_trip[k];
      end
    end
    assign ev[4*k]   = cfg_r[k][CFG_EV]   & st_start[k] & ~prv_start_r[k]; // [RULE_19]
    assign ev[4*k+1] = cfg_r[k][CFG_EV+1] & ~st_start[k] & prv_start_r[k]; // [RULE_19]
    assign ev[4*k+2] = cfg_r[k][CFG_EV+2] & st_trip[k] & ~prv_trip_r[k]; // [RULE_19]
    assign ev[4*k+3] = cfg_r[k][CFG_EV+3] & ~st_trip[k] & prv_trip_r[k]; // [RULE_19]
  end

  // ----------------------------------------
  // Output matrix
  // ----------------------------------------
  // Any of the three sources may clear the latches
  assign latch_clr = cmd_clr_r | key_s2_r | (di_rst_r & din_s2_r); // [RULE_13] [RULE_14]

  for (genvar c = 0; c < N_SRC * N_DST; c++) begin : g_lat
    // Source high beats a simultaneous clear
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        lat_r[c] <= 1'b0;
      end else if (route_r[c] && src[c / N_DST]) begin
        lat_r[c] <= 1'b1; // [RULE_12]
      end else if (latch_clr) begin
        lat_r[c] <= 1'b0; // [RULE_13]
      end
    end
  end

  // Crossing c = source * 7 + destination
  always_comb begin
    mat_out = '0;
    for (int c = 0; c < N_SRC * N_DST; c++) begin
      if (route_r[c])
        mat_out[c % N_DST] = mat_out[c % N_DST] |
                             (latch_mode_r[c] ? lat_r[c] : src[c / N_DST]); // [RULE_11] [RULE_12]
    end
  end

  // ----------------------------------------
  // Breaker failure supervision
  // ----------------------------------------
  assign sup = pick(outs_r, bfc_r[BF_SUP_LSB +: 3]); // [RULE_09]

  breaker_failure_supervisor u_bf (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_tick    (tick_r),
    .i_sup     (sup),
    .i_inhibit (force_r), // [RULE_10]
    .i_dly     (bfd_r),
    .o_backup  (backup),
    .o_time    (bf_time)
  );

  // Backup ORs into its chosen output; force overrides all
  always_comb begin
    outs_nxt = mat_out;
    for (int d = 0; d < N_DST; d++) begin
      if (backup && bfc_r[BF_BAK_LSB +: 3] == 3'(d)) outs_nxt[d] = 1'b1; // [RULE_08] [RULE_09]
    end
    if (force_r) outs_nxt = force_val_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) outs_r <= '0;
    else         outs_r <= outs_nxt;
  end

  // Pins registered from outs_nxt in parallel with the output register
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_primary_trip_out <= 1'b0;
      o_backup_trip_out  <= 1'b0;
      o_alarm_outs       <= 3'h0;
      o_alarm_indicator  <= 1'b0;
      o_trip_indicator   <= 1'b0;
    end else begin
      o_primary_trip_out <= outs_nxt[0];
      o_backup_trip_out  <= outs_nxt[1];
      o_alarm_outs       <= outs_nxt[4:2];
      o_alarm_indicator  <= outs_nxt[5];
      o_trip_indicator   <= outs_nxt[6];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign ev[EV_BF] = backup & ~prv_backup_r;

  // Set beats clear so no event is lost
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      prv_backup_r <= 1'b0;
      irq_stat_r   <= '0;
      irq_en_r     <= '0;
      o_irq        <= 1'b0;
    end else begin
      prv_backup_r <= backup;
      if (we && i_address == A_IRQ_CLR)
        irq_stat_r <= (irq_stat_r & ~i_writedata[N_EV-1:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
      if (we && i_address == A_IRQ_EN) irq_en_r <= i_writedata[N_EV-1:0];
      o_irq <= |(irq_stat_r & irq_en_r);
    end
  end

endmodule // freq_relay_top

// ===== rtl/freq_stage.sv
`timescale 1ns/1ps
module freq_stage
  import relay_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_tick,
  input  wire logic [15:0] i_freq,
  input  wire logic [15:0] i_thr,
  input  wire logic [15:0] i_dly,
  input  wire logic        i_over,
  input  wire logic        i_block,
  input  wire logic        i_lv_block,
  output logic             o_start,
  output logic             o_trip,
  output logic [7:0]       o_pct,
  output logic [15:0]      o_start_count,
  output logic [15:0]      o_trip_count
);
  logic [15:0] cnt_r;
  logic        cond;
  logic        start_nxt;
  logic [23:0] prod;

  // Pickup test; low voltage holds the stage quiet
  assign cond = ~i_lv_block & (i_over ? (i_freq > i_thr) : (i_freq < i_thr)); // [RULE_02] [RULE_17] [RULE_18]
  // Blocked stage may not pick up, but keeps a running start
  assign start_nxt = cond & (o_start | ~i_block); // [RULE_15]
  assign prod = {8'h00, cnt_r} * 24'd100;

  // Start level
  always_ff @(posedge i_clk) begin
    if (!i_nrst) o_start <= 1'b0;
    else         o_start <= start_nxt;
  end

  // Definite-time counter, frozen while blocked
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !start_nxt) begin
      cnt_r <= 16'h0000; // [RULE_03]
    end else if (i_tick && !i_block && cnt_r < i_dly) begin
      cnt_r <= cnt_r + 16'h0001; // [RULE_15]
    end
  end

  // Trip and percentage come from the same count, so 100 meets trip
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !start_nxt) begin
      o_trip <= 1'b0;
      o_pct  <= 8'h00;
    end else if (cnt_r >= i_dly) begin
      o_trip <= 1'b1;     // [RULE_03]
      o_pct  <= PCT_FULL; // [RULE_04]
    end else begin
      o_trip <= 1'b0;
      o_pct  <= 8'((prod / {8'h00, i_dly})); // [RULE_04]
    end
  end

  // Counters wrap silently
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_start_count <= 16'h0000;
      o_trip_count  <= 16'h0000;
    end else begin
      if (start_nxt && !o_start) o_start_count <= o_start_count + 16'h0001; // [RULE_05]
      if (start_nxt && !o_trip && cnt_r >= i_dly)
        o_trip_count <= o_trip_count + 16'h0001; // [RULE_06]
    end
  end
endmodule // freq_stage

// ===== rtl/relay_pkg.sv
package relay_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ   = 10_000_000;
  localparam int TICK_MS  = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_LVB      = 8'h04;
  localparam logic [7:0] A_BF_CFG   = 8'h08;
  localparam logic [7:0] A_BF_DLY   = 8'h0C;
  localparam logic [7:0] A_ROUTE    = 8'h10;
  localparam logic [7:0] A_LATCH    = 8'h14;
  localparam logic [7:0] A_BLOCK    = 8'h18;
  localparam logic [7:0] A_FORCE    = 8'h1C;
  localparam logic [7:0] A_IRQ_STAT = 8'h20;
  localparam logic [7:0] A_IRQ_CLR  = 8'h24;
  localparam logic [7:0] A_IRQ_EN   = 8'h28;
  localparam logic [7:0] A_OUTS     = 8'h2C;
  localparam logic [7:0] A_BF_TIME  = 8'h30;
  localparam logic [7:0] A_STG_BASE = 8'h40;
  localparam logic [7:0] A_STG_STEP = 8'h20;
  localparam logic [7:0] S_THR      = 8'h00;
  localparam logic [7:0] S_DLY      = 8'h04;
  localparam logic [7:0] S_CFG      = 8'h08;
  localparam logic [7:0] S_CNT      = 8'h0C;
  localparam logic [7:0] S_STAT     = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_CLR   = 0;
  localparam int CTRL_DIRST = 1;
  localparam int CTRL_FORCE = 2;
  localparam int CFG_OVER   = 0;
  localparam int CFG_EV     = 4;
  localparam int BF_SUP_LSB = 0;
  localparam int BF_BAK_LSB = 4;
  localparam int N_STG      = 2;
  localparam int N_SRC      = 4;
  localparam int N_DST      = 7;
  localparam int N_BLK      = 5;
  localparam int N_EV       = 9;
  localparam int EV_BF      = 8;
  localparam logic [7:0] PCT_FULL = 8'h64;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] THR0_RST = 16'h13EC;
  localparam logic [15:0] THR1_RST = 16'h1450;
  localparam logic [15:0] DLY0_RST = 16'h0014;
  localparam logic [15:0] DLY1_RST = 16'h000A;
  localparam logic [7:0]  CFG_RST  = 8'hF1;
  localparam logic [7:0]  LVB_RST  = 8'h28;
  localparam logic [7:0]  BFC_RST  = 8'h10;
  localparam logic [15:0] BFD_RST  = 16'h0014;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage
